// ==== core/sib_bank.sv ====
// APB register bank holding serial port interrupt enables and flags
`default_nettype none

// Summary of operation
// - Second enable byte bit 5 enables port-1 transmit interrupt, resets to zero.
// - Second enable byte bit 4 enables port-1 receive interrupt, resets to zero.
// - First flag byte bit 7 is port-0 transmit flag, resets one, set when empty.
// - First flag byte bit 6 is port-0 receive flag, resets zero, set on character.
// - Second flag byte bit 5 is port-1 transmit flag, resets one, set when empty.
// - Second flag byte bit 4 is port-1 receive flag, resets zero, set on character.
// - Bits 7-6 and 3-0 of second bytes are untouched and read as zero.
// - First enable byte: port-0 transmit enable bit 7, receive bit 6, reset zero.
// - Writing a transmit buffer clears that port's transmit flag unless the buffer empties in the same cycle.
// - Reading a receive buffer clears that port's overrun bit, and its receive flag unless a character completes in the same cycle.
module sib_bank
  import sib_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port0_tx_taken,
  input wire logic port0_rx_done,
  input wire logic [CHAR_W-1:0] port0_rx_char,
  output logic [CHAR_W-1:0] port0_tx_char,
  output logic port0_tx_pending,
  input wire logic port1_tx_taken,
  input wire logic port1_rx_done,
  input wire logic [CHAR_W-1:0] port1_rx_char,
  output logic [CHAR_W-1:0] port1_tx_char,
  output logic port1_tx_pending,
  output logic port0_tx_irq_req,
  output logic port0_rx_irq_req,
  output logic port1_tx_irq_req,
  output logic port1_rx_irq_req,
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sib_port_if p0_if ();
  sib_port_if p1_if ();

  logic pready_reg;
  logic pslverr_reg;
  logic [DATA_W-1:0] prdata_reg;
  logic port0_tx_irq_enable_reg;
  logic port0_rx_irq_enable_reg;
  logic port1_tx_irq_enable_reg;
  logic port1_rx_irq_enable_reg;
  logic [EVT_W-1:0] evt_status_reg;
  logic [EVT_W-1:0] evt_mask_reg;
  logic [EVT_W-1:0] evt_status_next;
  logic [EVT_W-1:0] evt_mask_next;
  logic [EVT_W-1:0] evt_in;
  logic [EVT_W-1:0] evt_clear;
  logic port0_tx_req_reg;
  logic port0_rx_req_reg;
  logic port1_tx_req_reg;
  logic port1_rx_req_reg;
  logic irq_reg;
  logic [DATA_W-1:0] rdata_mux;
  logic [DATA_W-1:0] en_one_word;
  logic [DATA_W-1:0] en_two_word;
  logic [DATA_W-1:0] flag_one_word;
  logic [DATA_W-1:0] flag_two_word;
  logic [DATA_W-1:0] line_word;

  // ----------------------------------------------------------------
  // Bus phase decode
  // ----------------------------------------------------------------
  wire access = psel & penable;
  wire capture = access & ~pready_reg;
  wire done = access & pready_reg;
  wire wr_en = done & pwrite;
  wire rd_en = done & ~pwrite;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire hit_en_one = (paddr == OFS_IRQ_ENABLE_ONE);
  wire hit_en_two = (paddr == OFS_IRQ_ENABLE_TWO);
  wire hit_flag_one = (paddr == OFS_IRQ_FLAG_ONE);
  wire hit_flag_two = (paddr == OFS_IRQ_FLAG_TWO);
  wire hit_p0_tx = (paddr == OFS_PORT0_TX_BUFFER);
  wire hit_p0_rx = (paddr == OFS_PORT0_RX_BUFFER);
  wire hit_p1_tx = (paddr == OFS_PORT1_TX_BUFFER);
  wire hit_p1_rx = (paddr == OFS_PORT1_RX_BUFFER);
  wire hit_line = (paddr == OFS_LINE_STATUS);
  wire hit_status = (paddr == OFS_EVENT_STATUS);
  wire hit_mask = (paddr == OFS_EVENT_MASK);
  wire hit_any = hit_en_one | hit_en_two | hit_flag_one | hit_flag_two |
                 hit_p0_tx | hit_p0_rx | hit_p1_tx | hit_p1_rx |
                 hit_line | hit_status | hit_mask;

  // ----------------------------------------------------------------
  // Channel requests
  // ----------------------------------------------------------------
  assign p0_if.tx_wr = wr_en & hit_p0_tx;
  assign p0_if.rx_rd = rd_en & hit_p0_rx;
  assign p0_if.flag_wr = wr_en & hit_flag_one;
  assign p0_if.wdata = pwdata[CHAR_W-1:0];
  assign p0_if.flag_tx_wdata = pwdata[POS_P0_TX];
  assign p0_if.flag_rx_wdata = pwdata[POS_P0_RX];

  assign p1_if.tx_wr = wr_en & hit_p1_tx;
  assign p1_if.rx_rd = rd_en & hit_p1_rx;
  assign p1_if.flag_wr = wr_en & hit_flag_two;
  assign p1_if.wdata = pwdata[CHAR_W-1:0];
  assign p1_if.flag_tx_wdata = pwdata[POS_P1_TX];
  assign p1_if.flag_rx_wdata = pwdata[POS_P1_RX];

  // ----------------------------------------------------------------
  // Port channels
  // ----------------------------------------------------------------
  sib_port_chan u_port0 (
    .pclk(pclk),
    .presetn(presetn),
    .bus(p0_if.chan),
    .tx_taken(port0_tx_taken),
    .rx_done(port0_rx_done),
    .rx_char(port0_rx_char),
    .tx_char(port0_tx_char),
    .tx_pending(port0_tx_pending)
  );

  sib_port_chan u_port1 (
    .pclk(pclk),
    .presetn(presetn),
    .bus(p1_if.chan),
    .tx_taken(port1_tx_taken),
    .rx_done(port1_rx_done),
    .rx_char(port1_rx_char),
    .tx_char(port1_tx_char),
    .tx_pending(port1_tx_pending)
  );

  // ----------------------------------------------------------------
  // Read words
  // ----------------------------------------------------------------
  always_comb begin
    en_one_word = RST_WORD;
    en_one_word[POS_P0_TX] = port0_tx_irq_enable_reg;
    en_one_word[POS_P0_RX] = port0_rx_irq_enable_reg;
  end

  always_comb begin
    en_two_word = RST_WORD;
    en_two_word[POS_P1_TX] = port1_tx_irq_enable_reg;
    en_two_word[POS_P1_RX] = port1_rx_irq_enable_reg;
  end

  always_comb begin
    flag_one_word = RST_WORD;
    flag_one_word[POS_P0_TX] = p0_if.tx_flag;
    flag_one_word[POS_P0_RX] = p0_if.rx_flag;
  end

  always_comb begin
    flag_two_word = RST_WORD;
    flag_two_word[POS_P1_TX] = p1_if.tx_flag;
    flag_two_word[POS_P1_RX] = p1_if.rx_flag;
  end

  always_comb begin
    line_word = RST_WORD;
    line_word[POS_LS_OVR0] = p0_if.overrun;
    line_word[POS_LS_OVR1] = p1_if.overrun;
    line_word[POS_LS_TXF0] = p0_if.tx_full;
    line_word[POS_LS_TXF1] = p1_if.tx_full;
  end

  assign rdata_mux =
    hit_en_one ? en_one_word :
    hit_en_two ? en_two_word :
    hit_flag_one ? flag_one_word :
    hit_flag_two ? flag_two_word :
    hit_p0_tx ? {{(DATA_W-CHAR_W){1'b0}}, p0_if.tx_buf} :
    hit_p0_rx ? {{(DATA_W-CHAR_W){1'b0}}, p0_if.rx_buf} :
    hit_p1_tx ? {{(DATA_W-CHAR_W){1'b0}}, p1_if.tx_buf} :
    hit_p1_rx ? {{(DATA_W-CHAR_W){1'b0}}, p1_if.rx_buf} :
    hit_line ? line_word :
    hit_status ? {{(DATA_W-EVT_W){1'b0}}, evt_status_reg} :
    hit_mask ? {{(DATA_W-EVT_W){1'b0}}, evt_mask_reg} :
    RST_WORD;

  // ----------------------------------------------------------------
  // Bus response
  // ----------------------------------------------------------------
  wire pslverr_next = capture & ~hit_any;
  wire [DATA_W-1:0] prdata_next = (capture & ~pwrite) ? rdata_mux : RST_WORD;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= capture;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= pslverr_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= RST_WORD;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Enable bytes
  // ----------------------------------------------------------------
  wire wr_en_one = wr_en & hit_en_one;
  wire wr_en_two = wr_en & hit_en_two;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port0_tx_irq_enable_reg <= RST_ENABLE;
      port0_rx_irq_enable_reg <= RST_ENABLE;
    end else if (wr_en_one) begin
      port0_tx_irq_enable_reg <= pwdata[POS_P0_TX];
      port0_rx_irq_enable_reg <= pwdata[POS_P0_RX];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port1_tx_irq_enable_reg <= RST_ENABLE;
      port1_rx_irq_enable_reg <= RST_ENABLE;
    end else if (wr_en_two) begin
      port1_tx_irq_enable_reg <= pwdata[POS_P1_TX];
      port1_rx_irq_enable_reg <= pwdata[POS_P1_RX];
    end
  end

  // ----------------------------------------------------------------
  // Event status and mask
  // ----------------------------------------------------------------
  always_comb begin
    evt_in = RST_EVT;
    evt_in[POS_EV_TX0] = p0_if.tx_evt;
    evt_in[POS_EV_RX0] = p0_if.rx_evt;
    evt_in[POS_EV_OVR0] = p0_if.ovr_evt;
    evt_in[POS_EV_TX1] = p1_if.tx_evt;
    evt_in[POS_EV_RX1] = p1_if.rx_evt;
    evt_in[POS_EV_OVR1] = p1_if.ovr_evt;
  end

  assign evt_clear = (wr_en & hit_status) ? pwdata[EVT_W-1:0] : RST_EVT;
  // A new event in the clearing cycle stays recorded
  assign evt_status_next = (evt_status_reg & ~evt_clear) | evt_in;
  assign evt_mask_next = (wr_en & hit_mask) ? pwdata[EVT_W-1:0] : evt_mask_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status_reg <= RST_EVT;
    end else begin
      evt_status_reg <= evt_status_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_mask_reg <= RST_EVT;
    end else begin
      evt_mask_reg <= evt_mask_next;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  wire p0_tx_req = p0_if.tx_flag & port0_tx_irq_enable_reg;
  wire p0_rx_req = p0_if.rx_flag & port0_rx_irq_enable_reg;
  wire p1_tx_req = p1_if.tx_flag & port1_tx_irq_enable_reg;
  wire p1_rx_req = p1_if.rx_flag & port1_rx_irq_enable_reg;
  wire any_evt = |(evt_status_reg & evt_mask_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port0_tx_req_reg <= 1'b0;
    end else begin
      port0_tx_req_reg <= p0_tx_req;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port0_rx_req_reg <= 1'b0;
    end else begin
      port0_rx_req_reg <= p0_rx_req;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port1_tx_req_reg <= 1'b0;
    end else begin
      port1_tx_req_reg <= p1_tx_req;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port1_rx_req_reg <= 1'b0;
    end else begin
      port1_rx_req_reg <= p1_rx_req;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= any_evt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign port0_tx_irq_req = port0_tx_req_reg;
  assign port0_rx_irq_req = port0_rx_req_reg;
  assign port1_tx_irq_req = port1_tx_req_reg;
  assign port1_rx_irq_req = port1_rx_req_reg;
  assign irq = irq_reg;

endmodule

`default_nettype wire

// ==== core/sib_pkg.sv ====
// Constants and register map of the serial interrupt flag and enable bank
`default_nettype none

package sib_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CHAR_W = 8;
  localparam int EVT_W = 6;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE_ONE = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE_TWO = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_IRQ_FLAG_ONE = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_IRQ_FLAG_TWO = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_PORT0_TX_BUFFER = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_PORT0_RX_BUFFER = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_PORT1_TX_BUFFER = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_PORT1_RX_BUFFER = 12'h01C;
  localparam logic [ADDR_W-1:0] OFS_LINE_STATUS = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS = 12'h024;
  localparam logic [ADDR_W-1:0] OFS_EVENT_MASK = 12'h028;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_P0_TX = 7;
  localparam int POS_P0_RX = 6;
  localparam int POS_P1_TX = 5;
  localparam int POS_P1_RX = 4;
  localparam int POS_LS_OVR0 = 0;
  localparam int POS_LS_OVR1 = 1;
  localparam int POS_LS_TXF0 = 2;
  localparam int POS_LS_TXF1 = 3;
  localparam int POS_EV_TX0 = 0;
  localparam int POS_EV_RX0 = 1;
  localparam int POS_EV_OVR0 = 2;
  localparam int POS_EV_TX1 = 3;
  localparam int POS_EV_RX1 = 4;
  localparam int POS_EV_OVR1 = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RST_TX_FLAG = 1'b1;
  localparam logic RST_RX_FLAG = 1'b0;
  localparam logic RST_ENABLE = 1'b0;
  localparam logic [CHAR_W-1:0] RST_CHAR = 8'h00;
  localparam logic [EVT_W-1:0] RST_EVT = 6'h00;
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

endpackage

`default_nettype wire

// ==== core/sib_port_chan.sv ====
// Buffers, flags and overrun state of one serial port
`default_nettype none

module sib_port_chan
  import sib_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  sib_port_if.chan bus,
  input wire logic tx_taken,
  input wire logic rx_done,
  input wire logic [CHAR_W-1:0] rx_char,
  output logic [CHAR_W-1:0] tx_char,
  output logic tx_pending
);

  // ----------------------------------------------------------------
  // Next-state terms
  // ----------------------------------------------------------------
  logic tx_flag_reg;
  logic rx_flag_reg;
  logic overrun_reg;
  logic tx_full_reg;
  logic [CHAR_W-1:0] tx_buf_reg;
  logic [CHAR_W-1:0] rx_buf_reg;
  logic tx_flag_next;
  logic rx_flag_next;
  logic overrun_next;
  logic tx_full_next;
  wire ovr_hit = rx_done & rx_flag_reg & ~bus.rx_rd;

  // Buffer empty sets the flag, a buffer write clears it, set wins
  assign tx_flag_next = tx_taken ? 1'b1 :
                        bus.tx_wr ? 1'b0 :
                        bus.flag_wr ? bus.flag_tx_wdata : tx_flag_reg;
  // A complete character sets the flag, a buffer read clears it
  assign rx_flag_next = rx_done ? 1'b1 :
                        bus.rx_rd ? 1'b0 :
                        bus.flag_wr ? bus.flag_rx_wdata : rx_flag_reg;
  assign overrun_next = ovr_hit ? 1'b1 : (bus.rx_rd ? 1'b0 : overrun_reg);
  assign tx_full_next = bus.tx_wr ? 1'b1 : (tx_taken ? 1'b0 : tx_full_reg);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_flag_reg <= RST_TX_FLAG;
      rx_flag_reg <= RST_RX_FLAG;
      overrun_reg <= 1'b0;
      tx_full_reg <= 1'b0;
      tx_buf_reg <= RST_CHAR;
      rx_buf_reg <= RST_CHAR;
    end else begin
      tx_flag_reg <= tx_flag_next;
      rx_flag_reg <= rx_flag_next;
      overrun_reg <= overrun_next;
      tx_full_reg <= tx_full_next;
      tx_buf_reg <= bus.tx_wr ? bus.wdata : tx_buf_reg;
      rx_buf_reg <= rx_done ? rx_char : rx_buf_reg;
    end
  end

  assign bus.tx_flag = tx_flag_reg;
  assign bus.rx_flag = rx_flag_reg;
  assign bus.overrun = overrun_reg;
  assign bus.tx_full = tx_full_reg;
  assign bus.tx_buf = tx_buf_reg;
  assign bus.rx_buf = rx_buf_reg;
  assign bus.tx_evt = tx_taken;
  assign bus.rx_evt = rx_done;
  assign bus.ovr_evt = ovr_hit;
  assign tx_char = tx_buf_reg;
  assign tx_pending = tx_full_reg;

endmodule

`default_nettype wire

// ==== core/sib_port_if.sv ====
// Signals between the register bank and one serial port channel
`default_nettype none

interface sib_port_if;
  import sib_pkg::*;
  logic tx_wr;
  logic rx_rd;
  logic flag_wr;
  logic [CHAR_W-1:0] wdata;
  logic flag_tx_wdata;
  logic flag_rx_wdata;
  logic tx_flag;
  logic rx_flag;
  logic overrun;
  logic tx_full;
  logic [CHAR_W-1:0] tx_buf;
  logic [CHAR_W-1:0] rx_buf;
  logic tx_evt;
  logic rx_evt;
  logic ovr_evt;

  modport bank (
    output tx_wr, rx_rd, flag_wr, wdata, flag_tx_wdata, flag_rx_wdata,
    input tx_flag, rx_flag, overrun, tx_full, tx_buf, rx_buf, tx_evt, rx_evt, ovr_evt
  );
  modport chan (
    input tx_wr, rx_rd, flag_wr, wdata, flag_tx_wdata, flag_rx_wdata,
    output tx_flag, rx_flag, overrun, tx_full, tx_buf, rx_buf, tx_evt, rx_evt, ovr_evt
  );
endinterface

`default_nettype wire

// ==== verif/sib_bank_props.sv ====
// Concurrent checks on the ports of the serial interrupt bank
`default_nettype none

module sib_bank_props
  import sib_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic port0_tx_taken,
  input wire logic port0_rx_done,
  input wire logic [CHAR_W-1:0] port0_rx_char,
  input wire logic [CHAR_W-1:0] port0_tx_char,
  input wire logic port0_tx_pending,
  input wire logic port1_tx_taken,
  input wire logic port1_rx_done,
  input wire logic [CHAR_W-1:0] port1_rx_char,
  input wire logic [CHAR_W-1:0] port1_tx_char,
  input wire logic port1_tx_pending,
  input wire logic port0_tx_irq_req,
  input wire logic port0_rx_irq_req,
  input wire logic port1_tx_irq_req,
  input wire logic port1_rx_irq_req,
  input wire logic irq
);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire logic wr_done = pready && pwrite;
  wire logic rd_done = pready && !pwrite;
  wire logic bad_addr = (paddr > OFS_EVENT_MASK) || (paddr[1:0] != 2'h0);
  wire logic spare_rd = rd_done && (paddr == OFS_IRQ_ENABLE_TWO || paddr == OFS_IRQ_FLAG_TWO);
  wire logic [CHAR_W-1:0] wr_byte = pwdata[CHAR_W-1:0];

  // ----------------------------------------------------------------
  // Bus and register checks
  // ----------------------------------------------------------------
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  wait_state_a: assert property ((psel && !penable) ##1 (psel && penable) |=> pready)
    else $error("pready missing in second access cycle");
  error_decode_a: assert property (pready |-> pslverr == bad_addr)
    else $error("pslverr does not match address decode");
  idle_data_a: assert property (!rd_done |-> prdata == RST_WORD)
    else $error("prdata not zero outside read completion");
  spare_bits_a: assert property (spare_rd |-> prdata[7:6] == 2'h0 && prdata[3:0] == 4'h0)
    else $error("bits of other modules read nonzero");
  reset_quiet_a: assert property ($rose(presetn) |-> (!port0_tx_irq_req && !port1_tx_irq_req)[*2])
    else $error("request high right after reset");
  enable_off_a: assert property (
    wr_done && paddr == OFS_IRQ_ENABLE_ONE && !pwdata[POS_P0_TX] |-> ##2 !port0_tx_irq_req)
    else $error("request stays high with enable cleared");
  tx_write_clear_a: assert property (
    wr_done && paddr == OFS_PORT1_TX_BUFFER && !port1_tx_taken |=> ##1 !port1_tx_irq_req)
    else $error("transmit flag not cleared by buffer write");
  tx_load_a: assert property (wr_done && paddr == OFS_PORT0_TX_BUFFER
    |=> port0_tx_pending && port0_tx_char == $past(wr_byte))
    else $error("transmit buffer not loaded");
  rx_read_clear_a: assert property (
    rd_done && paddr == OFS_PORT1_RX_BUFFER && !port1_rx_done |=> ##1 !port1_rx_irq_req)
    else $error("receive flag not cleared by buffer read");
  mask_off_a: assert property (wr_done && paddr == OFS_EVENT_MASK && wr_byte[EVT_W-1:0] == RST_EVT
    |=> ##1 !irq)
    else $error("irq high with all events masked");
endmodule

bind sib_bank sib_bank_props props_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .port0_tx_taken(port0_tx_taken),
  .port0_rx_done(port0_rx_done), .port0_rx_char(port0_rx_char),
  .port0_tx_char(port0_tx_char), .port0_tx_pending(port0_tx_pending),
  .port1_tx_taken(port1_tx_taken), .port1_rx_done(port1_rx_done),
  .port1_rx_char(port1_rx_char), .port1_tx_char(port1_tx_char),
  .port1_tx_pending(port1_tx_pending), .port0_tx_irq_req(port0_tx_irq_req),
  .port0_rx_irq_req(port0_rx_irq_req), .port1_tx_irq_req(port1_tx_irq_req),
  .port1_rx_irq_req(port1_rx_irq_req), .irq(irq));

`default_nettype wire

// ==== verif/sib_bank_tb_top.sv ====
// Self-checking bench for the serial interrupt bank
`default_nettype none

module sib_bank_tb_top
  import sib_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [3:0] strb;
  logic [CHAR_W-1:0] ch;
  logic [CHAR_W-1:0] tx0;
  logic [CHAR_W-1:0] tx1;
  logic [1:0] pend;
  logic [1:0] txq;
  logic [1:0] rxq;
  logic [DATA_W-1:0] rd;
  logic err;
  int num_errors = 0;
  int comparisons = 0;

  always #10 pclk = ~pclk;

  sib_bank dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port0_tx_taken(strb[0]), .port0_rx_done(strb[1]),
    .port0_rx_char(ch), .port0_tx_char(tx0), .port0_tx_pending(pend[0]),
    .port1_tx_taken(strb[2]), .port1_rx_done(strb[3]), .port1_rx_char(ch),
    .port1_tx_char(tx1), .port1_tx_pending(pend[1]), .port0_tx_irq_req(txq[0]),
    .port0_rx_irq_req(rxq[0]), .port1_tx_irq_req(txq[1]), .port1_rx_irq_req(rxq[1]),
    .irq(irq));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    check(n < 20, 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
    check(err, e);
  endtask

  task automatic pulse(input logic [3:0] s, input logic [CHAR_W-1:0] c);
    @(posedge pclk);
    strb <= s;
    ch <= c;
    @(posedge pclk);
    strb <= 4'h0;
    @(negedge pclk);
    @(negedge pclk);
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [ADDR_W-1:0] fa;
    logic [ADDR_W-1:0] ba;
    logic [DATA_W-1:0] tm;
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    strb = 4'h0;
    ch = 8'h00;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(OFS_IRQ_ENABLE_ONE, 32'h0, 1'b0);
    rdc(OFS_IRQ_ENABLE_TWO, 32'h0, 1'b0);
    rdc(OFS_IRQ_FLAG_ONE, 32'h80, 1'b0);
    rdc(OFS_IRQ_FLAG_TWO, 32'h20, 1'b0);
    check({rxq, txq}, 4'h0);
    $display("Test reset values done");
    apb(1'b1, OFS_IRQ_ENABLE_TWO, 32'hFF);
    rdc(OFS_IRQ_ENABLE_TWO, 32'h30, 1'b0);
    apb(1'b1, OFS_IRQ_FLAG_TWO, 32'hEF);
    rdc(OFS_IRQ_FLAG_TWO, 32'h20, 1'b0);
    apb(1'b1, OFS_IRQ_ENABLE_ONE, 32'hFF);
    rdc(OFS_IRQ_ENABLE_ONE, 32'hC0, 1'b0);
    check({rxq, txq}, 4'h3);
    $display("Test enables done");
    for (int p = 0; p < 2; p++) begin
      fa = (p == 1) ? OFS_IRQ_FLAG_TWO : OFS_IRQ_FLAG_ONE;
      ba = (p == 1) ? OFS_PORT1_TX_BUFFER : OFS_PORT0_TX_BUFFER;
      tm = (p == 1) ? 32'h20 : 32'h80;
      apb(1'b1, ba, 32'h1A5);
      check((p == 1) ? tx1 : tx0, 8'hA5);
      check(pend[p], 1'b1);
      check(txq[p], 1'b0);
      rdc(fa, 32'h0, 1'b0);
      pulse(4'h1 << (2 * p), 8'h00);
      check(pend[p], 1'b0);
      check(txq[p], 1'b1);
      pulse(4'h2 << (2 * p), 8'h3C);
      check(rxq[p], 1'b1);
      rdc(fa, tm | (tm >> 1), 1'b0);
      pulse(4'h2 << (2 * p), 8'h4D);
      rdc(OFS_LINE_STATUS, 32'h1 << p, 1'b0);
      rdc(ba + 12'h004, 32'h4D, 1'b0);
      rdc(OFS_LINE_STATUS, 32'h0, 1'b0);
      check(rxq[p], 1'b0);
      rdc(fa, tm, 1'b0);
    end
    $display("Test port flags done");
    rdc(OFS_EVENT_STATUS, 32'h3F, 1'b0);
    check(irq, 1'b0);
    apb(1'b1, OFS_EVENT_MASK, 32'h3F);
    check(irq, 1'b1);
    apb(1'b1, OFS_EVENT_STATUS, 32'h3F);
    rdc(OFS_EVENT_STATUS, 32'h0, 1'b0);
    check(irq, 1'b0);
    apb(1'b1, OFS_EVENT_MASK, 32'h02);
    pulse(4'h8, 8'h11);
    check(irq, 1'b0);
    pulse(4'h2, 8'h22);
    check(irq, 1'b1);
    apb(1'b1, OFS_EVENT_MASK, 32'h0);
    check(irq, 1'b0);
    $display("Test events done");
    apb(1'b1, OFS_IRQ_ENABLE_ONE, 32'h0);
    apb(1'b1, OFS_IRQ_ENABLE_TWO, 32'h0);
    check({rxq, txq}, 4'h0);
    rdc(12'h030, 32'h0, 1'b1);
    apb(1'b1, 12'h02E, 32'hFF);
    check(err, 1'b1);
    apb(1'b1, OFS_LINE_STATUS, 32'hF);
    rdc(OFS_LINE_STATUS, 32'h0, 1'b0);
    rdc(OFS_IRQ_ENABLE_ONE, 32'h0, 1'b0);
    $display("Test refusals done");
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    complete_run();
  end
endmodule

`default_nettype wire
